// File: rtl/m3ar_autorange.sv
// Round-robin conversion sequencer with dual-range auto-ranging for the receive-power channel
// Summary of operation
// - Convert all channels round-robin after reset.
// - Receive slot starts with fine conversion, shifted.
// - Same slot decides fine report or coarse conversion.
// - Coarse uses coarse gain, offset, no shift.
// - Fine uses fine gain, offset, 3-bit shift.
// - Fine maximum threshold indexed by shift count.
// - Coarse minimum threshold indexed by shift count.
// - Hysteresis prevents chatter near range boundary.
// - Either range writes the same result register.
// - Range indicator bit shows latest reported range.
// - Both force bits reset zero: auto-ranging on.
// - Force-fine alone disables auto-ranging.
// - Disabled means plain fine conversion with shift.
// - Either force bit alone locks fine or coarse range.
// - Shift applied before storing fine result.
`timescale 1ns/1ps
`include "m3ar_cfg.svh"
module m3ar_autorange (
	input  wire logic                mclk,
	input  wire logic                reset_n,
	input  wire m3ar_pkg::m3ar_byte_t regAddr,
	input  wire logic                regWrEn,
	input  wire m3ar_pkg::m3ar_byte_t regWrData,
	output      m3ar_pkg::m3ar_byte_t regRdData,
	output      logic                adcStart,
	output      m3ar_pkg::m3ar_chan_t adcChannel,
	output      m3ar_pkg::m3ar_word_t adcGain,
	output      m3ar_pkg::m3ar_word_t adcOffset,
	input  wire logic                adcDone,
	input  wire m3ar_pkg::m3ar_word_t adcResult
);
	import m3ar_pkg::*;

	logic        rstMeta_r;
	logic        rstSync_r;
	m3ar_state_t state_r;
	m3ar_state_t state_nxt;
	m3ar_chan_t  slot_r;
	m3ar_chan_t  slot_nxt;
	m3ar_word_t  fineHold_r;
	m3ar_word_t  fineHold_nxt;
	m3ar_word_t  result_r;
	m3ar_word_t  result_nxt;
	logic        rangeCoarse_r;
	logic        rangeCoarse_nxt;
	logic        report;
	m3ar_byte_t  config_r;
	m3ar_byte_t  shiftReg_r;
	m3ar_word_t  fineGain_r;
	m3ar_word_t  coarseGain_r;
	m3ar_word_t  fineOfs_r;
	m3ar_word_t  coarseOfs_r;
	logic        newFlag_r;
	m3ar_byte_t  config_nxt;
	m3ar_byte_t  shiftReg_nxt;
	m3ar_word_t  fineGain_nxt;
	m3ar_word_t  coarseGain_nxt;
	m3ar_word_t  fineOfs_nxt;
	m3ar_word_t  coarseOfs_nxt;

	m3ar_cal_if cal ();

	m3ar_cal_unit calUnit (
		.cal (cal.unit)
	);

	// Reset release through two flops
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rstMeta_r <= 1'b0;
			rstSync_r <= 1'b0;
		end else begin
			rstMeta_r <= 1'b1;
			rstSync_r <= rstMeta_r;
		end
	end

	// Mode decode from the force bits of the configuration register, which reset clears to zero
	wire forceFine   = config_r[`M3AR_CFG_FF_BIT] & ~config_r[`M3AR_CFG_FC_BIT];
	wire forceCoarse = config_r[`M3AR_CFG_FC_BIT] & ~config_r[`M3AR_CFG_FF_BIT];
	wire autoRange   = ~forceFine & ~forceCoarse;

	wire isRxSlot    = (slot_r == `M3AR_CHANNEL_RX);
	wire coarsePhase = (state_r == ST_COARSE_START) || (state_r == ST_COARSE_WAIT);

	assign cal.raw        = adcResult;
	assign cal.shiftCount = shiftReg_r[`M3AR_SHIFT_MSB:`M3AR_SHIFT_LSB];

	// Hysteresis: after a fine report only a fine value at its maximum calls for a coarse conversion,
	// and that coarse result is reported as it stands. After a coarse report every receive slot converts coarse
	// again and keeps it while the raw coarse value stays at or above the coarse minimum; below it the
	// fine value held from the start of the slot is reported. A forced range bypasses both tests.
	wire fineAtMax   = (cal.fineValue >= cal.fineMax);
	wire needCoarse  = forceCoarse | (autoRange & (rangeCoarse_r | fineAtMax));
	wire coarseValid = (adcResult >= cal.coarseMin);
	wire keepCoarse  = forceCoarse | ~rangeCoarse_r | coarseValid;

	assign adcStart   = (state_r == ST_START) || (state_r == ST_COARSE_START);
	assign adcChannel = slot_r;
	assign adcGain    = coarsePhase ? coarseGain_r : fineGain_r;
	assign adcOffset  = coarsePhase ? coarseOfs_r : fineOfs_r;

	always_comb begin
		state_nxt       = state_r;
		slot_nxt        = slot_r;
		fineHold_nxt    = fineHold_r;
		result_nxt      = result_r;
		rangeCoarse_nxt = rangeCoarse_r;
		report          = 1'b0;
		unique case (state_r)
			ST_IDLE: begin
				state_nxt = ST_START;
			end
			ST_START: begin
				state_nxt = ST_WAIT;
			end
			ST_WAIT: begin
				if (adcDone) begin
					if (!isRxSlot) begin
						state_nxt = ST_NEXT;
					end else if (needCoarse) begin
						fineHold_nxt = cal.fineValue;
						state_nxt    = ST_COARSE_START;
					end else begin
						result_nxt      = cal.fineValue;
						rangeCoarse_nxt = 1'b0;
						report          = 1'b1;
						state_nxt       = ST_NEXT;
					end
				end
			end
			ST_COARSE_START: begin
				state_nxt = ST_COARSE_WAIT;
			end
			ST_COARSE_WAIT: begin
				if (adcDone) begin
					report    = 1'b1;
					state_nxt = ST_NEXT;
					if (keepCoarse) begin
						result_nxt      = adcResult;
						rangeCoarse_nxt = 1'b1;
					end else begin
						result_nxt      = fineHold_r;
						rangeCoarse_nxt = 1'b0;
					end
				end
			end
			ST_NEXT: begin
				slot_nxt  = (slot_r == `M3AR_CHANNEL_LAST) ? `M3AR_CHANNEL_FIRST : slot_r + 3'h1;
				state_nxt = ST_START;
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// Sequencer position
	always_ff @(posedge mclk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			state_r <= ST_IDLE;
			slot_r  <= `M3AR_CHANNEL_FIRST;
		end else begin
			state_r <= state_nxt;
			slot_r  <= slot_nxt;
		end
	end

	// Reported result, fine value held across a coarse conversion, and the range used
	always_ff @(posedge mclk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			fineHold_r    <= `M3AR_RESET_WORD;
			result_r      <= `M3AR_RESET_WORD;
			rangeCoarse_r <= 1'b0;
		end else begin
			fineHold_r    <= fineHold_nxt;
			result_r      <= result_nxt;
			rangeCoarse_r <= rangeCoarse_nxt;
		end
	end

	// Register write decode
	wire wrConfig  = regWrEn && (regAddr == `M3AR_ADDR_CONFIG);
	wire wrShift   = regWrEn && (regAddr == `M3AR_ADDR_SHIFT);
	wire wrUpdate  = regWrEn && (regAddr == `M3AR_ADDR_UPDATE);
	wire wrFGainHi = regWrEn && (regAddr == `M3AR_ADDR_FGAIN_HI);
	wire wrFGainLo = regWrEn && (regAddr == `M3AR_ADDR_FGAIN_LO);
	wire wrCGainHi = regWrEn && (regAddr == `M3AR_ADDR_CGAIN_HI);
	wire wrCGainLo = regWrEn && (regAddr == `M3AR_ADDR_CGAIN_LO);
	wire wrFOfsHi  = regWrEn && (regAddr == `M3AR_ADDR_FOFS_HI);
	wire wrFOfsLo  = regWrEn && (regAddr == `M3AR_ADDR_FOFS_LO);
	wire wrCOfsHi  = regWrEn && (regAddr == `M3AR_ADDR_COFS_HI);
	wire wrCOfsLo  = regWrEn && (regAddr == `M3AR_ADDR_COFS_LO);

	// Writing zero to the new-result flag clears it; a report in the same cycle wins
	wire newFlagClr = wrUpdate && !regWrData[`M3AR_UPD_NEW_BIT];

	// Configuration and shift bytes are stored whole
	assign config_nxt   = wrConfig ? regWrData : config_r;
	assign shiftReg_nxt = wrShift ? regWrData : shiftReg_r;

	always_ff @(posedge mclk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			config_r <= `M3AR_RESET_BYTE;
		end else begin
			config_r <= config_nxt;
		end
	end

	always_ff @(posedge mclk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			shiftReg_r <= `M3AR_RESET_BYTE;
		end else begin
			shiftReg_r <= shiftReg_nxt;
		end
	end

	always_ff @(posedge mclk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			newFlag_r <= 1'b0;
		end else if (report) begin
			newFlag_r <= 1'b1;
		end else if (newFlagClr) begin
			newFlag_r <= 1'b0;
		end
	end

	// Calibration words take each byte on its own write; there is no atomic latch of the pair
	assign fineGain_nxt   = {wrFGainHi ? regWrData : fineGain_r[15:8], wrFGainLo ? regWrData : fineGain_r[7:0]};
	assign coarseGain_nxt = {wrCGainHi ? regWrData : coarseGain_r[15:8], wrCGainLo ? regWrData : coarseGain_r[7:0]};
	assign fineOfs_nxt    = {wrFOfsHi ? regWrData : fineOfs_r[15:8], wrFOfsLo ? regWrData : fineOfs_r[7:0]};
	assign coarseOfs_nxt  = {wrCOfsHi ? regWrData : coarseOfs_r[15:8], wrCOfsLo ? regWrData : coarseOfs_r[7:0]};

	always_ff @(posedge mclk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			fineGain_r <= `M3AR_RESET_WORD;
		end else begin
			fineGain_r <= fineGain_nxt;
		end
	end

	always_ff @(posedge mclk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			coarseGain_r <= `M3AR_RESET_WORD;
		end else begin
			coarseGain_r <= coarseGain_nxt;
		end
	end

	always_ff @(posedge mclk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			fineOfs_r <= `M3AR_RESET_WORD;
		end else begin
			fineOfs_r <= fineOfs_nxt;
		end
	end

	always_ff @(posedge mclk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			coarseOfs_r <= `M3AR_RESET_WORD;
		end else begin
			coarseOfs_r <= coarseOfs_nxt;
		end
	end

	// Status byte holds the range indicator and the new-result flag
	wire [7:0] updateByte = ({7'h00, rangeCoarse_r} << `M3AR_UPD_RANGE_BIT)
	                      | ({7'h00, newFlag_r} << `M3AR_UPD_NEW_BIT);

	// Read address decode; unmapped addresses read as zero
	wire rdResultHi = (regAddr == `M3AR_ADDR_RESULT_HI);
	wire rdResultLo = (regAddr == `M3AR_ADDR_RESULT_LO);
	wire rdUpdate   = (regAddr == `M3AR_ADDR_UPDATE);
	wire rdConfig   = (regAddr == `M3AR_ADDR_CONFIG);
	wire rdShift    = (regAddr == `M3AR_ADDR_SHIFT);
	wire rdFGainHi  = (regAddr == `M3AR_ADDR_FGAIN_HI);
	wire rdFGainLo  = (regAddr == `M3AR_ADDR_FGAIN_LO);
	wire rdCGainHi  = (regAddr == `M3AR_ADDR_CGAIN_HI);
	wire rdCGainLo  = (regAddr == `M3AR_ADDR_CGAIN_LO);
	wire rdFOfsHi   = (regAddr == `M3AR_ADDR_FOFS_HI);
	wire rdFOfsLo   = (regAddr == `M3AR_ADDR_FOFS_LO);
	wire rdCOfsHi   = (regAddr == `M3AR_ADDR_COFS_HI);
	wire rdCOfsLo   = (regAddr == `M3AR_ADDR_COFS_LO);

	assign regRdData =
		rdResultHi ? result_r[15:8] :
		rdResultLo ? result_r[7:0] :
		rdUpdate   ? updateByte :
		rdConfig   ? config_r :
		rdShift    ? shiftReg_r :
		rdFGainHi  ? fineGain_r[15:8] :
		rdFGainLo  ? fineGain_r[7:0] :
		rdCGainHi  ? coarseGain_r[15:8] :
		rdCGainLo  ? coarseGain_r[7:0] :
		rdFOfsHi   ? fineOfs_r[15:8] :
		rdFOfsLo   ? fineOfs_r[7:0] :
		rdCOfsHi   ? coarseOfs_r[15:8] :
		rdCOfsLo   ? coarseOfs_r[7:0] :
		`M3AR_RESET_BYTE;
endmodule : m3ar_autorange

// File: rtl/m3ar_cfg.svh
// Register offsets, field positions, reset values and range thresholds for the receive-power auto-ranger
`ifndef M3AR_CFG_SVH
`define M3AR_CFG_SVH

`define M3AR_ADDR_RESULT_HI   8'h68
`define M3AR_ADDR_RESULT_LO   8'h69
`define M3AR_ADDR_UPDATE      8'h6F
`define M3AR_ADDR_CONFIG      8'h8B
`define M3AR_ADDR_SHIFT       8'h8F
`define M3AR_ADDR_FGAIN_HI    8'h98
`define M3AR_ADDR_FGAIN_LO    8'h99
`define M3AR_ADDR_CGAIN_HI    8'h9C
`define M3AR_ADDR_CGAIN_LO    8'h9D
`define M3AR_ADDR_FOFS_HI     8'hA8
`define M3AR_ADDR_FOFS_LO     8'hA9
`define M3AR_ADDR_COFS_HI     8'hAC
`define M3AR_ADDR_COFS_LO     8'hAD

`define M3AR_UPD_RANGE_BIT    2
`define M3AR_UPD_NEW_BIT      3
`define M3AR_CFG_FF_BIT       0
`define M3AR_CFG_FC_BIT       1
`define M3AR_SHIFT_MSB        6
`define M3AR_SHIFT_LSB        4

`define M3AR_RESET_BYTE       8'h00
`define M3AR_RESET_WORD       16'h0000

`define M3AR_CHANNEL_FIRST    3'h0
`define M3AR_CHANNEL_LAST     3'h5
`define M3AR_CHANNEL_RX       3'h4

`define M3AR_FINE_MAX_0       16'hFFF8
`define M3AR_FINE_MAX_1       16'h7FFC
`define M3AR_FINE_MAX_2       16'h3FFE
`define M3AR_FINE_MAX_3       16'h1FFF
`define M3AR_FINE_MAX_4       16'h0FFF
`define M3AR_FINE_MAX_5       16'h07FF
`define M3AR_FINE_MAX_6       16'h03FF
`define M3AR_FINE_MAX_7       16'h01FF

`define M3AR_COARSE_MIN_0     16'hF000
`define M3AR_COARSE_MIN_1     16'h7800
`define M3AR_COARSE_MIN_2     16'h3C00
`define M3AR_COARSE_MIN_3     16'h1E00
`define M3AR_COARSE_MIN_4     16'h0F00
`define M3AR_COARSE_MIN_5     16'h0780
`define M3AR_COARSE_MIN_6     16'h03C0
`define M3AR_COARSE_MIN_7     16'h01E0

`endif

// File: rtl/m3ar_pkg.sv
// Types shared by the receive-power auto-ranger
package m3ar_pkg;
	typedef logic [15:0] m3ar_word_t;
	typedef logic [7:0]  m3ar_byte_t;
	typedef logic [2:0]  m3ar_shift_t;
	typedef logic [2:0]  m3ar_chan_t;

	typedef enum logic [2:0] {
		ST_IDLE         = 3'b000,
		ST_START        = 3'b001,
		ST_WAIT         = 3'b010,
		ST_COARSE_START = 3'b011,
		ST_COARSE_WAIT  = 3'b100,
		ST_NEXT         = 3'b101
	} m3ar_state_t;
endpackage : m3ar_pkg

// File: rtl/m3ar_cal_if.sv
// Interface between the sequencer and the shift and threshold unit
`timescale 1ns/1ps
interface m3ar_cal_if;
	import m3ar_pkg::*;
	m3ar_word_t  raw;
	m3ar_shift_t shiftCount;
	m3ar_word_t  fineValue;
	m3ar_word_t  fineMax;
	m3ar_word_t  coarseMin;

	modport host (output raw, output shiftCount, input fineValue, input fineMax, input coarseMin);
	modport unit (input raw, input shiftCount, output fineValue, output fineMax, output coarseMin);
endinterface : m3ar_cal_if

// File: rtl/m3ar_cal_unit.sv
// Right-shift of the fine result and hysteresis thresholds for the current shift count
`timescale 1ns/1ps
`include "m3ar_cfg.svh"
module m3ar_cal_unit (
	m3ar_cal_if.unit cal
);
	import m3ar_pkg::*;

	assign cal.fineValue = cal.raw >> cal.shiftCount;

	always_comb begin
		unique case (cal.shiftCount)
			3'h0: begin
				cal.fineMax   = `M3AR_FINE_MAX_0;
				cal.coarseMin = `M3AR_COARSE_MIN_0;
			end
			3'h1: begin
				cal.fineMax   = `M3AR_FINE_MAX_1;
				cal.coarseMin = `M3AR_COARSE_MIN_1;
			end
			3'h2: begin
				cal.fineMax   = `M3AR_FINE_MAX_2;
				cal.coarseMin = `M3AR_COARSE_MIN_2;
			end
			3'h3: begin
				cal.fineMax   = `M3AR_FINE_MAX_3;
				cal.coarseMin = `M3AR_COARSE_MIN_3;
			end
			3'h4: begin
				cal.fineMax   = `M3AR_FINE_MAX_4;
				cal.coarseMin = `M3AR_COARSE_MIN_4;
			end
			3'h5: begin
				cal.fineMax   = `M3AR_FINE_MAX_5;
				cal.coarseMin = `M3AR_COARSE_MIN_5;
			end
			3'h6: begin
				cal.fineMax   = `M3AR_FINE_MAX_6;
				cal.coarseMin = `M3AR_COARSE_MIN_6;
			end
			3'h7: begin
				cal.fineMax   = `M3AR_FINE_MAX_7;
				cal.coarseMin = `M3AR_COARSE_MIN_7;
			end
		endcase
	end
endmodule : m3ar_cal_unit

// File: verification/m3ar_autorange_monitor.sv
// Port-level checks for the receive-power auto-ranger
`timescale 1ns/1ps
`include "m3ar_cfg.svh"
module m3ar_autorange_monitor (
	input wire logic                 mclk,
	input wire logic                 reset_n,
	input wire m3ar_pkg::m3ar_byte_t regAddr,
	input wire logic                 regWrEn,
	input wire m3ar_pkg::m3ar_byte_t regWrData,
	input wire m3ar_pkg::m3ar_byte_t regRdData,
	input wire logic                 adcStart,
	input wire m3ar_pkg::m3ar_chan_t adcChannel,
	input wire m3ar_pkg::m3ar_word_t adcGain,
	input wire m3ar_pkg::m3ar_word_t adcOffset,
	input wire logic                 adcDone,
	input wire m3ar_pkg::m3ar_word_t adcResult
);
	import m3ar_pkg::*;
	m3ar_chan_t      lastCh_r;
	wire m3ar_chan_t nextCh = (lastCh_r == `M3AR_CHANNEL_LAST) ? `M3AR_CHANNEL_FIRST : lastCh_r + 3'h1;
	wire logic       rwAddr = regAddr inside {8'h8B, 8'h8F, 8'h98, 8'h99, 8'h9C, 8'h9D, 8'hA8, 8'hA9, 8'hAC, 8'hAD};
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);
	// Channel of the most recent conversion request
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			lastCh_r <= `M3AR_CHANNEL_LAST;
		end else if (adcStart) begin
			lastCh_r <= adcChannel;
		end
	end
	property p_startPulse; adcStart |=> !adcStart; endproperty
	a_startPulse: assert property (p_startPulse) else $error("start pulse too long");
	property p_waitQuiet; adcStart ##1 !adcDone |=> !adcStart; endproperty
	a_waitQuiet: assert property (p_waitQuiet) else $error("start while waiting");
	property p_doneNext; adcDone |-> ##[1:2] adcStart; endproperty
	a_doneNext: assert property (p_doneNext) else $error("no start after done");
	property p_order; adcStart && adcChannel != lastCh_r |-> adcChannel == nextCh; endproperty
	a_order: assert property (p_order) else $error("channel order broken");
	property p_repeatRx; adcStart && adcChannel == lastCh_r |-> adcChannel == `M3AR_CHANNEL_RX; endproperty
	a_repeatRx: assert property (p_repeatRx) else $error("second conversion off rx channel");
	property p_hold; adcStart |=> $stable(adcChannel) && $stable(adcGain) && $stable(adcOffset); endproperty
	a_hold: assert property (p_hold) else $error("conversion settings moved");
	property p_regWrite; regWrEn && rwAddr ##1 $stable(regAddr) |-> regRdData == $past(regWrData); endproperty
	a_regWrite: assert property (p_regWrite) else $error("register write lost");
	property p_resultRo;
		regWrEn && regAddr inside {8'h68, 8'h69} && !adcDone ##1 $stable(regAddr) |-> $stable(regRdData);
	endproperty
	a_resultRo: assert property (p_resultRo) else $error("result written by software");
	property p_updSpare; regAddr == 8'h6F |-> regRdData[7:4] == 4'h0 && regRdData[1:0] == 2'h0; endproperty
	a_updSpare: assert property (p_updSpare) else $error("spare update bits set");
endmodule : m3ar_autorange_monitor

// File: verification/m3ar_autorange_tb.sv
// Self-checking bench for the receive-power auto-ranger
`timescale 1ns/1ps
`include "m3ar_cfg.svh"
module m3ar_autorange_tb;
	import m3ar_pkg::*;
	typedef struct packed {
		m3ar_byte_t cfg;
		m3ar_byte_t sh;
		m3ar_word_t fine;
		m3ar_word_t coarse;
		logic       twice;
		logic       rng;
	} m3ar_row_t;
	m3ar_row_t  rows [10] = '{
		'{8'h00, 8'h30, 16'h8000, 16'h0000, 1'b0, 1'b0}, '{8'h00, 8'h30, 16'hFFF8, 16'h5000, 1'b1, 1'b1},
		'{8'h00, 8'h30, 16'hF000, 16'h1E00, 1'b1, 1'b1}, '{8'h00, 8'h30, 16'hEFF8, 16'h1DFF, 1'b1, 1'b0},
		'{8'h00, 8'h30, 16'hFFF0, 16'h0000, 1'b0, 1'b0}, '{8'h01, 8'h30, 16'hFFFF, 16'h0000, 1'b0, 1'b0},
		'{8'h02, 8'h30, 16'h0000, 16'h0100, 1'b1, 1'b1}, '{8'h03, 8'h30, 16'h0800, 16'h0010, 1'b1, 1'b0},
		'{8'h00, 8'h70, 16'hFF80, 16'h0200, 1'b1, 1'b1}, '{8'h00, 8'h00, 16'h0000, 16'hF000, 1'b1, 1'b1}};
	m3ar_byte_t calAddr [4] = '{8'h98, 8'h9C, 8'hA8, 8'hAC};
	m3ar_word_t cal [4] = '{16'h1234, 16'h5678, 16'h9ABC, 16'hDEF0};
	logic       mclk, reset_n, regWrEn, adcDone, adcStart;
	m3ar_byte_t regAddr, regWrData, regRdData;
	m3ar_chan_t adcChannel, ch;
	m3ar_word_t adcGain, adcOffset, adcResult, g, o, e;
	int         fails, numChecks;
	m3ar_autorange DUT (.mclk(mclk), .reset_n(reset_n), .regAddr(regAddr), .regWrEn(regWrEn),
		.regWrData(regWrData), .regRdData(regRdData), .adcStart(adcStart), .adcChannel(adcChannel),
		.adcGain(adcGain), .adcOffset(adcOffset), .adcDone(adcDone), .adcResult(adcResult));
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	task automatic tick; @(posedge mclk); #2; endtask : tick
	task automatic chk16(input m3ar_word_t got, input m3ar_word_t exp);
		numChecks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk16
	task automatic wr(input m3ar_byte_t a, input m3ar_byte_t d);
		regAddr = a;
		regWrData = d;
		regWrEn = 1'b1;
		tick;
		regWrEn = 1'b0;
		tick;
	endtask : wr
	task automatic rd(input m3ar_byte_t a, input m3ar_byte_t exp);
		regAddr = a;
		#1;
		chk16({8'h00, regRdData}, {8'h00, exp});
	endtask : rd
	task automatic startWait;
		for (int i = 0; i < 40 && adcStart !== 1'b1; i++) tick;
		chk16({15'h0000, adcStart}, 16'h0001);
		ch = adcChannel;
		g = adcGain;
		o = adcOffset;
	endtask : startWait
	// Answer in the second wait cycle, after one quiet one, then drive a non-repeating value
	task automatic finish(input m3ar_word_t raw);
		tick;
		tick;
		adcDone = 1'b1;
		adcResult = raw;
		tick;
		adcDone = 1'b0;
		adcResult = ~raw;
	endtask : finish
	task automatic print_verdict;
		if (fails == 0 && numChecks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : print_verdict
	initial begin
		#200000;
		fails++;
		print_verdict;
	end
	initial begin
		{reset_n, regWrEn, adcDone, regAddr, regWrData, adcResult} = '0;
		fails = 0;
		numChecks = 0;
		repeat (6) @(posedge mclk);
		#2;
		rd(`M3AR_ADDR_CONFIG, 8'h00);
		chk16(adcGain, 16'h0000);
		reset_n = 1'b1;
		// Catch the first start, then keep calibration writes off its hold cycle
		startWait;
		chk16({13'h0000, ch}, 16'h0000);
		tick;
		for (int k = 0; k < 4; k++) begin
			wr(calAddr[k], cal[k][15:8]);
			wr(calAddr[k] + 8'h01, cal[k][7:0]);
			rd(calAddr[k], cal[k][15:8]);
		end
		foreach (rows[i]) begin
			wr(`M3AR_ADDR_CONFIG, rows[i].cfg);
			wr(`M3AR_ADDR_SHIFT, rows[i].sh);
			for (int k = 0; k < 6 && ch !== `M3AR_CHANNEL_RX; k++) begin
				finish(16'h0000);
				startWait;
			end
			chk16(g, cal[0]);
			chk16(o, cal[2]);
			finish(rows[i].fine);
			startWait;
			chk16({13'h0000, ch}, rows[i].twice ? 16'h0004 : 16'h0005);
			if (rows[i].twice) begin
				chk16(g, cal[1]);
				chk16(o, cal[3]);
			end
			finish(rows[i].coarse);
			startWait;
			e = rows[i].rng ? rows[i].coarse : rows[i].fine >> rows[i].sh[6:4];
			rd(`M3AR_ADDR_RESULT_HI, e[15:8]);
			rd(`M3AR_ADDR_RESULT_LO, e[7:0]);
			rd(`M3AR_ADDR_UPDATE, {4'h0, 1'b1, rows[i].rng, 2'h0});
			wr(`M3AR_ADDR_UPDATE, 8'h00);
			rd(`M3AR_ADDR_UPDATE, {5'h00, rows[i].rng, 2'h0});
		end
		wr(`M3AR_ADDR_RESULT_HI, 8'hFF);
		rd(`M3AR_ADDR_RESULT_HI, e[15:8]);
		wr(8'h50, 8'h5A);
		rd(8'h50, 8'h00);
		wr(`M3AR_ADDR_CONFIG, 8'h03);
		reset_n = 1'b0;
		tick;
		chk16({15'h0000, adcStart}, 16'h0000);
		rd(`M3AR_ADDR_CONFIG, 8'h00);
		rd(`M3AR_ADDR_FGAIN_HI, 8'h00);
		reset_n = 1'b1;
		startWait;
		chk16({13'h0000, ch}, 16'h0000);
		print_verdict;
	end
endmodule : m3ar_autorange_tb
bind m3ar_autorange m3ar_autorange_monitor u_mon (.mclk(mclk), .reset_n(reset_n), .regAddr(regAddr),
	.regWrEn(regWrEn), .regWrData(regWrData), .regRdData(regRdData), .adcStart(adcStart),
	.adcChannel(adcChannel), .adcGain(adcGain), .adcOffset(adcOffset), .adcDone(adcDone), .adcResult(adcResult));
